// File: design/sacs_cfg.svh
// Timing counts and code constants for the conversion sequencer
`ifndef SACS_CFG_SVH
`define SACS_CFG_SVH
`define SACS_DIV_RATIO 4
`define SACS_CONV_CYC_12 49
`define SACS_CONV_CYC_14 57
`define SACS_CONV_CYC_16 65
`define SACS_STROBE_EXTRA_NS 50
`define SACS_CLK_PERIOD_NS 4
`define SACS_STROBE_MIN_CYC ((`SACS_STROBE_EXTRA_NS + `SACS_CLK_PERIOD_NS - 1) / `SACS_CLK_PERIOD_NS)
`define SACS_OSC_LOW_CYC 8
`endif

// File: design/sacs_pkg.sv
// Types for the conversion sequencer
package sacs_pkg;
  typedef enum logic [3:0] {
    SACS_TRACK = 4'b0001,
    SACS_SYNC = 4'b0010,
    SACS_TRIAL = 4'b0100,
    SACS_CAL = 4'b1000
  } sacs_state_e;
endpackage : sacs_pkg

// File: design/sacs_sequencer.sv
// Successive-approximation conversion sequencer with calibration and clock select
// Functional notes
// - Conversion starts at half scale trial code
// - Clear bit if input below, try next
// - Try every bit once; final code result
// - Clamp to all ones or all zeros
// - Bipolar: MSB element tied to reference tracking
// - Bipolar output is offset binary
// - Idle means track, elements follow input
// - Conversion ignores input, uses held charge
// - Calibrate bit weight to lower sum plus dummy
// - Master clock input low selects oscillator
// - Durations counted in master clock cycles
// - Falling strobe holds input, starts conversion
// - Return to track automatically when done
// - Strobe still low restarts conversion
// - Sequencing runs on master clock divided four
// - Start may lag strobe up to four cycles
// - Conversion lasts at least 49/57/65 cycles
`timescale 1ns/1ps
`include "sacs_cfg.svh"
module sacs_sequencer
  import sacs_pkg::*;
#(
  parameter int NBITS = 16,
  parameter int CONV_CYC = `SACS_CONV_CYC_16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Control pins
  input wire logic hold_n_i,
  input wire logic master_clock_input_i,
  input wire logic bipolar_i,
  input wire logic cal_start_i,
  // Analog front end
  input wire logic cmp_below_i,
  input wire logic over_range_i,
  input wire logic under_range_i,
  output logic sample_switch_o,
  output logic msb_to_ref_o,
  output logic [NBITS-1:0] trial_code_o,
  output logic [NBITS-1:0] cal_select_o,
  output logic cal_trim_up_o,
  output logic use_osc_o,
  // Results
  output logic [NBITS-1:0] result_o,
  output logic eoc_n_o,
  output logic busy_o
);

  //--------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------
  logic [2:0] hold_sync;
  logic [2:0] next_hold_sync;
  logic [2:0] mck_sync;
  logic [2:0] next_mck_sync;
  logic hold_lvl;
  logic next_hold_lvl;
  logic mck_lvl;
  logic next_mck_lvl;
  logic hold_fall;

  // Three stages; level changes once stages two and three agree
  always_comb begin
    next_hold_sync = {hold_sync[1:0], hold_n_i};
    next_mck_sync = {mck_sync[1:0], master_clock_input_i};
    next_hold_lvl = (hold_sync[1] == hold_sync[2]) ? hold_sync[2] : hold_lvl;
    next_mck_lvl = (mck_sync[1] == mck_sync[2]) ? mck_sync[2] : mck_lvl;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hold_sync <= 3'h7;
      mck_sync <= 3'h0;
      hold_lvl <= 1'b1;
      mck_lvl <= 1'b0;
    end else begin
      hold_sync <= next_hold_sync;
      mck_sync <= next_mck_sync;
      hold_lvl <= next_hold_lvl;
      mck_lvl <= next_mck_lvl;
    end
  end

  // Falling edge of the filtered strobe
  assign hold_fall = hold_lvl & ~next_hold_lvl;

  //--------------------------------------------------------------
  // Master clock source select
  //--------------------------------------------------------------
  logic [3:0] osc_cnt;
  logic [3:0] next_osc_cnt;
  logic use_osc;
  logic next_use_osc;

  // Input low for a while means oscillator; input going high means external clock
  always_comb begin
    next_osc_cnt = mck_lvl ? 4'h0 :
      ((osc_cnt == 4'(`SACS_OSC_LOW_CYC)) ? osc_cnt : osc_cnt + 4'h1);
    next_use_osc = (osc_cnt == 4'(`SACS_OSC_LOW_CYC));
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      osc_cnt <= 4'h0;
      use_osc <= 1'b0;
    end else begin
      osc_cnt <= next_osc_cnt;
      use_osc <= next_use_osc;
    end
  end

  assign use_osc_o = use_osc;

  //--------------------------------------------------------------
  // Divide by four tick
  //--------------------------------------------------------------
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic tick;

  // Internal sequencing clock as enable pulse
  always_comb begin
    next_div_cnt = div_cnt + 2'h1;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  assign tick = (div_cnt == 2'(`SACS_DIV_RATIO - 1));

  //--------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------
  localparam int CW = $clog2(CONV_CYC + 1);
  localparam int BW = $clog2(NBITS + 1);
  sacs_state_e state;
  sacs_state_e next_state;
  logic [NBITS-1:0] code;
  logic [NBITS-1:0] next_code;
  logic [NBITS-1:0] bit_ptr;
  logic [NBITS-1:0] next_bit_ptr;
  logic [CW-1:0] cyc;
  logic [CW-1:0] next_cyc;
  logic [NBITS-1:0] result;
  logic [NBITS-1:0] next_result;
  logic eoc_n;
  logic next_eoc_n;
  logic trim_up;
  logic next_trim_up;
  logic [BW-1:0] tried;
  logic [BW-1:0] next_tried;

  // State, trial code and result updates
  always_comb begin
    next_state = state;
    next_code = code;
    next_bit_ptr = bit_ptr;
    next_cyc = cyc;
    next_result = result;
    next_eoc_n = eoc_n;
    next_trim_up = trim_up;
    next_tried = tried;
    unique case (state)
      SACS_TRACK: begin
        // Idle: elements follow the input
        if (cal_start_i) begin
          next_state = SACS_CAL;
          next_bit_ptr = {1'b0, {(NBITS-1){1'b0}}} | NBITS'(2); // start at bit 1
          next_eoc_n = 1'b1;
          next_tried = '0; // A strobe held through calibration must not restart
        end else if (hold_fall) begin
          next_state = SACS_SYNC;
          next_cyc = '0;
        end else if (!hold_lvl && tried == BW'(NBITS)) begin
          next_state = SACS_SYNC;
          next_cyc = '0;
          next_tried = '0;
        end
      end
      SACS_SYNC: begin
        // Wait for the divided clock: up to four cycles late
        next_cyc = cyc + CW'(1);
        if (tick) begin
          next_state = SACS_TRIAL;
          next_code = {1'b1, {(NBITS-1){1'b0}}};
          next_bit_ptr = {1'b1, {(NBITS-1){1'b0}}};
          next_tried = '0;
        end
      end
      SACS_TRIAL: begin
        // One trial per divided tick, held charge only
        if (cyc != CW'(CONV_CYC)) begin
          next_cyc = cyc + CW'(1);
        end
        if (tick && bit_ptr != '0) begin
          next_code = cmp_below_i ? (code & ~bit_ptr) : code;
          next_code = next_code | (bit_ptr >> 1);
          next_bit_ptr = bit_ptr >> 1;
          next_tried = tried + BW'(1);
        end
        if (bit_ptr == '0 && cyc == CW'(CONV_CYC)) begin
          if (over_range_i) begin
            next_result = '1;
          end else if (under_range_i) begin
            next_result = '0;
          end else begin
            next_result = code;
          end
          next_eoc_n = 1'b0;
          next_state = SACS_TRACK;
        end
      end
      SACS_CAL: begin
        // Trim each weight from bit 1 up to the MSB against lower sum plus dummy unit
        if (tick) begin
          next_trim_up = cmp_below_i;
          next_bit_ptr = bit_ptr << 1;
          if (bit_ptr[NBITS-1]) begin
            next_state = SACS_TRACK;
            next_eoc_n = 1'b0;
            next_bit_ptr = '0;
          end
        end
      end
      default: next_state = SACS_TRACK;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= SACS_TRACK;
      code <= '0;
      bit_ptr <= '0;
      cyc <= '0;
      result <= '0;
      eoc_n <= 1'b1;
      trim_up <= 1'b0;
      tried <= '0;
    end else begin
      state <= next_state;
      code <= next_code;
      bit_ptr <= next_bit_ptr;
      cyc <= next_cyc;
      result <= next_result;
      eoc_n <= next_eoc_n;
      trim_up <= next_trim_up;
      tried <= next_tried;
    end
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------
  // Switch closed only while tracking; hold begins on the strobe edge
  assign sample_switch_o = (state == SACS_TRACK) && !hold_fall;
  assign msb_to_ref_o = bipolar_i && (state == SACS_TRACK);
  assign trial_code_o = code;
  assign cal_select_o = (state == SACS_CAL) ? (bit_ptr - NBITS'(1)) : '0;
  assign cal_trim_up_o = trim_up;
  assign result_o = result;
  assign eoc_n_o = eoc_n;
  assign busy_o = (state != SACS_TRACK);

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------
  property p_start_half;
    @(posedge clk_i) disable iff (srst_i)
      (state == SACS_SYNC && tick) |=> (code == {1'b1, {(NBITS-1){1'b0}}});
  endproperty
  a_start_half: assert property (p_start_half) else $error("trial not half scale");

  property p_sync_bound;
    @(posedge clk_i) disable iff (srst_i)
      (state == SACS_TRACK && hold_fall && !cal_start_i) |=> (state == SACS_SYNC)
        ##[1:4] (state == SACS_TRIAL);
  endproperty
  a_sync_bound: assert property (p_sync_bound) else $error("start lag too long");

  property p_min_time;
    @(posedge clk_i) disable iff (srst_i)
      (state == SACS_TRIAL && next_state == SACS_TRACK) |-> (cyc == CW'(CONV_CYC));
  endproperty
  a_min_time: assert property (p_min_time) else $error("conversion too short");

  property p_all_bits;
    @(posedge clk_i) disable iff (srst_i)
      $rose(!busy_o) && $past(state) == SACS_TRIAL |-> (tried == BW'(NBITS));
  endproperty
  a_all_bits: assert property (p_all_bits) else $error("bits not all tried");

  property p_track_idle;
    @(posedge clk_i) disable iff (srst_i)
      (state != SACS_TRACK) |-> !sample_switch_o;
  endproperty
  a_track_idle: assert property (p_track_idle) else $error("switch closed in conversion");

  property p_done_eoc;
    @(posedge clk_i) disable iff (srst_i)
      (state == SACS_TRIAL && next_state == SACS_TRACK) |=> (!eoc_n_o && !busy_o);
  endproperty
  a_done_eoc: assert property (p_done_eoc) else $error("no return to track");

  property p_clamp;
    @(posedge clk_i) disable iff (srst_i)
      (state == SACS_TRIAL && next_state == SACS_TRACK && over_range_i) |=> (result_o == '1);
  endproperty
  a_clamp: assert property (p_clamp) else $error("over range not clamped");

  property p_div;
    @(posedge clk_i) disable iff (srst_i)
      tick |=> !tick ##1 !tick ##1 !tick ##1 tick;
  endproperty
  a_div: assert property (p_div) else $error("divider not four");

  property p_msb_ref;
    @(posedge clk_i) disable iff (srst_i)
      (bipolar_i && state == SACS_TRACK) |-> msb_to_ref_o;
  endproperty
  a_msb_ref: assert property (p_msb_ref) else $error("bipolar MSB not on reference");

endmodule : sacs_sequencer

// File: dv/sacs_afe_model.sv
// Comparator and range-flag model of the analog side
`timescale 1ns/1ps
module sacs_afe_model #(
  parameter int NBITS = 16
) (
  // Clock
  input wire logic clk_i,
  // From the sequencer
  input wire logic sample_switch_i,
  input wire logic [NBITS-1:0] trial_code_i,
  input wire logic [NBITS-1:0] cal_select_i,
  // Analog level given as a code
  input wire logic [NBITS-1:0] level_i,
  input wire logic over_i,
  input wire logic under_i,
  // To the sequencer
  output logic cmp_below_o,
  output logic over_range_o,
  output logic under_range_o
);
  logic [NBITS-1:0] held;
  logic held_over;
  logic held_under;
  // Follow the input while tracking, keep the charge once the switch opens
  always_ff @(posedge clk_i) begin
    if (sample_switch_i) begin
      held <= level_i;
      held_over <= over_i;
      held_under <= under_i;
    end
  end
  // Held level against the trial level; in calibration every weight reads low
  assign cmp_below_o = (cal_select_i != '0) ? 1'b1 : (held < trial_code_i);
  assign over_range_o = held_over;
  assign under_range_o = held_under;
endmodule : sacs_afe_model

// File: dv/sacs_sequencer_tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module sacs_sequencer_tb;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic hold_n = 1'b1;
  logic mci = 1'b0;
  logic run = 1'b1;
  logic bip = 1'b0;
  logic cal = 1'b0;
  logic ov = 1'b0;
  logic un = 1'b0;
  logic [15:0] level = 16'h0000;
  logic cmp, ovr, unr, sw, m2r, use_osc, eoc_n, busy, trim;
  logic [15:0] code, result, sel;
  logic mci_ph = 1'b0;
  int err_count = 0;
  int cmp_count = 0;
  // Clock and external master clock pin
  always #2 clk_i = ~clk_i;
  // Pin level held two cycles so the three-stage filter can follow it
  always @(negedge clk_i) begin
    mci_ph <= ~mci_ph;
    if (mci_ph) mci <= run ? ~mci : 1'b0;
  end
  sacs_sequencer DUT (.clk_i(clk_i), .srst_i(srst_i), .hold_n_i(hold_n),
    .master_clock_input_i(mci), .bipolar_i(bip), .cal_start_i(cal),
    .cmp_below_i(cmp), .over_range_i(ovr), .under_range_i(unr),
    .sample_switch_o(sw), .msb_to_ref_o(m2r), .trial_code_o(code),
    .cal_select_o(sel), .cal_trim_up_o(trim), .use_osc_o(use_osc),
    .result_o(result), .eoc_n_o(eoc_n), .busy_o(busy));
  sacs_afe_model afe (.clk_i(clk_i), .sample_switch_i(sw), .trial_code_i(code),
    .cal_select_i(sel),
    .level_i(level), .over_i(ov), .under_i(un), .cmp_below_o(cmp),
    .over_range_o(ovr), .under_range_o(unr));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_busy(input logic val, input int bound);
    int n;
    n = 0;
    while (busy !== val) begin
      @(negedge clk_i);
      n++;
      if (n > bound) begin
        check({15'h0000, busy}, {15'h0000, val});
        test_done();
      end
    end
  endtask : wait_busy
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic conv(input logic [15:0] lv, input logic b, o, u, input logic [15:0] exp);
    int n;
    logic seen, go;
    seen = 1'b0;
    go = 1'b0;
    @(negedge clk_i);
    level = lv;
    bip = b;
    ov = o;
    un = u;
    @(negedge clk_i);
    hold_n = 1'b0;
    for (n = 1; n < 120; n++) begin
      @(negedge clk_i);
      if (n == 10) level = ~lv;
      if (n == 20) hold_n = 1'b1;
      if (n == 30) check({15'h0000, sw | m2r}, 16'h0000);
      if (busy === 1'b1 && code === 16'h8000) seen = 1'b1;
      if (busy === 1'b1) go = 1'b1;
      if (go && busy === 1'b0) break;
    end
    // Filter fill, up to four cycles of lag, then at least the minimum time
    check((n >= 68 && n <= 73) ? 16'h0046 : n[15:0], 16'h0046);
    if (n >= 120) test_done();
    check({15'h0000, seen}, 16'h0001);
    check(result, exp);
    check({14'h0000, eoc_n, sw}, 16'h0001);
    check({15'h0000, m2r}, {15'h0000, b});
    $display("conversion of %h done", lv);
  endtask : conv
  task automatic restart();
    @(negedge clk_i);
    hold_n = 1'b0;
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 100);
    wait_busy(1'b1, 12);
    hold_n = 1'b1;
    wait_busy(1'b0, 100);
    check({15'h0000, eoc_n}, 16'h0000);
    $display("restart test done");
  endtask : restart
  task automatic calib();
    logic [15:0] r;
    logic [15:0] prev;
    int n;
    int steps;
    r = result;
    steps = 0;
    @(negedge clk_i);
    cal = 1'b1;
    @(negedge clk_i);
    cal = 1'b0;
    hold_n = 1'b0;
    check({15'h0000, busy}, 16'h0001);
    check({15'h0000, eoc_n}, 16'h0001);
    check(sel, 16'h0001);
    prev = sel;
    // Each step moves to the next weight, trimmed against all lower bits
    for (n = 1; n < 200 && busy === 1'b1; n++) begin
      @(negedge clk_i);
      if (n == 20) hold_n = 1'b1;
      if (busy === 1'b1 && sel !== prev) begin
        check(sel, {prev[14:0], 1'b1});
        check({15'h0000, trim}, 16'h0001);
        steps++;
        prev = sel;
      end
    end
    check({15'h0000, busy}, 16'h0000);
    if (n >= 200) test_done();
    check(prev, 16'h7FFF);
    check(steps[15:0], 16'h000E);
    check({14'h0000, eoc_n, sw}, 16'h0001);
    check(result, r);
    $display("calibration test done");
  endtask : calib
  task automatic clock_select();
    check({15'h0000, use_osc}, 16'h0000);
    run = 1'b0;
    repeat (20) @(negedge clk_i);
    check({15'h0000, use_osc}, 16'h0001);
    run = 1'b1;
    repeat (20) @(negedge clk_i);
    check({15'h0000, use_osc}, 16'h0000);
    $display("clock select test done");
  endtask : clock_select
  task automatic reset_check();
    @(negedge clk_i);
    check(result, 16'h0000);
    check({13'h0000, eoc_n, busy, sw}, 16'h0005);
    check({15'h0000, use_osc}, 16'h0000);
    repeat (4) @(negedge clk_i);
    $display("reset test done");
  endtask : reset_check
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge clk_i);
    srst_i = 1'b0;
    reset_check();
    conv(16'h1234, 1'b0, 1'b0, 1'b0, 16'h1234);
    conv(16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000);
    conv(16'hFFFF, 1'b0, 1'b0, 1'b0, 16'hFFFF);
    conv(16'hA5A5, 1'b1, 1'b0, 1'b0, 16'hA5A5);
    conv(16'h1234, 1'b0, 1'b1, 1'b0, 16'hFFFF);
    conv(16'h1234, 1'b1, 1'b0, 1'b1, 16'h0000);
    restart();
    calib();
    clock_select();
    test_done();
  end
endmodule : sacs_sequencer_tb
